// File: inc/ocmp_pkg.sv
// Shared constants, register map and types for the output compare channel
package ocmp_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int VAL_W = 16;
  localparam int MODE_W = 3;
  localparam int IRQ_W = 3;
  localparam int PTG_W = 8;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL1 = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_CTRL2 = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PRI = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_SEC = 8'h0C;
  localparam logic [ADDR_W-1:0] ADDR_TMR = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_PERIOD = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h1C;

  // Field positions
  localparam int CTRL1_MODE_LSB = 0;
  localparam int CTRL1_POLICY_BIT = 3;
  localparam int CTRL1_CLKSEL_BIT = 4;
  localparam int CTRL2_TRIGGER_STATUS_FLAG_BIT = 6;
  localparam int IRQ_PRI_BIT = 0;
  localparam int IRQ_SEC_BIT = 1;
  localparam int IRQ_TRIG_BIT = 2;

  // Reset values
  localparam logic [VAL_W-1:0] VAL_RST = 16'h0000;
  localparam logic [VAL_W-1:0] PERIOD_RST = 16'hFFFF;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
  localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h00000000;

  // Trigger generator outputs 4..7 serve channels 1..4
  localparam int CHANNEL_NUM = 1;
  localparam int PTG_FIRST_OUT = 4;
  localparam int PTG_SEL = PTG_FIRST_OUT + CHANNEL_NUM - 1;

  typedef enum logic [MODE_W-1:0] {
    MODE_OFF = 3'h0,
    MODE_SS_HIGH = 3'h1,
    MODE_SS_LOW = 3'h2,
    MODE_TOGGLE = 3'h3,
    MODE_DBL_SINGLE = 3'h4,
    MODE_DBL_CONT = 3'h5,
    MODE_EPWM = 3'h6,
    MODE_CPWM = 3'h7
  } mode_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_WAIT_PRI = 4'h2,
    ST_WAIT_SEC = 4'h4,
    ST_DONE = 4'h8
  } seq_state_t;

  function automatic logic is_pwm(input mode_t m);
    is_pwm = (m == MODE_EPWM) || (m == MODE_CPWM);
  endfunction

endpackage

// File: src/channel_timer.sv
// Free-running channel timer with software load and period rollover
`timescale 1ns/1ps
module channel_timer
  import ocmp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Control
  input wire logic tick,
  input wire logic load,
  input wire logic [ocmp_pkg::VAL_W-1:0] load_val,
  input wire logic [ocmp_pkg::VAL_W-1:0] period,
  // Status
  output logic [ocmp_pkg::VAL_W-1:0] count,
  output logic wrap
);

  logic [VAL_W-1:0] count_r;
  logic [VAL_W-1:0] count_nxt;

  assign wrap = tick && (count_r == period);
  assign count_nxt = load ? load_val : (wrap ? VAL_RST : count_r + 16'h0001);
  assign count = count_r;

  // A software load wins over counting so the written value is seen exactly
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      count_r <= VAL_RST;
    else if (load || tick)
      count_r <= count_nxt;
  end

endmodule

// File: src/output_compare_channel.sv
// Output compare channel with APB registers, compare modes and interrupt
`timescale 1ns/1ps
// Notes on behaviour
// - Policy one: secondary match or software clears flag
// - Policy zero: only software clears trigger flag
// - Mode 111: high on primary, low secondary
// - Mode 110: high at zero, low primary
// - Mode 101: start low, alternate toggles continuously
// - Mode 100: start low, one pulse only
// - Mode 011: toggle on every primary match
// - Mode 010: start high, low on primary
// - Mode 001: start low, high on primary
// - Mode 000: channel disabled, no output activity
// - Compare values double-buffered in PWM modes only
// - Clock source is trigger generator output three-plus-channel
module output_compare_channel
  import ocmp_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic [ocmp_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ocmp_pkg::DATA_W-1:0] pwdata,
  output logic [ocmp_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Trigger sources
  input wire logic [ocmp_pkg::PTG_W-1:0] peripheral_trigger_generator,
  input wire logic trigger_event,
  // Compare output and interrupt
  output logic compare_output_pin,
  output logic irq
);

  // Bus state
  logic pready_r;
  logic [DATA_W-1:0] prdata_r;
  logic pslverr_r;

  // Registers
  mode_t compare_mode_select_r;
  logic trigger_clear_policy_r;
  logic clk_sel_r;
  logic trigger_status_flag_r;
  logic [VAL_W-1:0] pri_shadow_r;
  logic [VAL_W-1:0] sec_shadow_r;
  logic [VAL_W-1:0] pri_active_r;
  logic [VAL_W-1:0] sec_active_r;
  logic [VAL_W-1:0] period_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic irq_r;

  // Compare engine state
  logic out_r;
  logic out_nxt;
  seq_state_t st_r;
  seq_state_t st_nxt;
  logic step_r;

  // Bus decode
  wire setup_rd = psel && penable && !pready_r;
  wire access = psel && penable && pready_r;
  wire wr = access && pwrite;
  wire hit_ctrl1 = (paddr == ADDR_CTRL1);
  wire hit_ctrl2 = (paddr == ADDR_CTRL2);
  wire hit_pri = (paddr == ADDR_PRI);
  wire hit_sec = (paddr == ADDR_SEC);
  wire hit_tmr = (paddr == ADDR_TMR);
  wire hit_period = (paddr == ADDR_PERIOD);
  wire hit_stat = (paddr == ADDR_IRQ_STAT);
  wire hit_mask = (paddr == ADDR_IRQ_MASK);
  wire addr_hit = hit_ctrl1 || hit_ctrl2 || hit_pri || hit_sec || hit_tmr || hit_period || hit_stat || hit_mask;

  wire mode_wr = wr && hit_ctrl1;
  wire mode_t mode_new = mode_t'(pwdata[CTRL1_MODE_LSB +: MODE_W]);
  wire sw_trig_clr = wr && hit_ctrl2 && pwdata[CTRL2_TRIGGER_STATUS_FLAG_BIT];
  wire tmr_load = wr && hit_tmr;
  wire [IRQ_W-1:0] stat_w1c = (wr && hit_stat) ? pwdata[IRQ_W-1:0] : IRQ_RST;

  // Timer
  wire pwm_mode = is_pwm(compare_mode_select_r);
  wire ptg_clk = peripheral_trigger_generator[PTG_SEL];
  // Channel timer advances on its own generator output when selected
  wire tick = (compare_mode_select_r != MODE_OFF) && (clk_sel_r ? ptg_clk : 1'b1);
  wire [VAL_W-1:0] timer_val;
  wire timer_wrap;

  channel_timer u_timer (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .tick(tick),
    .load(tmr_load),
    .load_val(pwdata[VAL_W-1:0]),
    .period(period_r),
    .count(timer_val),
    .wrap(timer_wrap)
  );

  // Values in use: buffered copies in PWM, shadows directly otherwise
  wire [VAL_W-1:0] pri_use = pwm_mode ? pri_active_r : pri_shadow_r;
  wire [VAL_W-1:0] sec_use = pwm_mode ? sec_active_r : sec_shadow_r;

  // A stalled timer must not re-fire the same match every cycle
  wire pri_match = step_r && (timer_val == pri_use);
  wire sec_match = step_r && (timer_val == sec_use);
  wire zero_match = step_r && (timer_val == VAL_RST);

  // Read mux
  wire [DATA_W-1:0] rd_ctrl1 = {27'h0000000, clk_sel_r, trigger_clear_policy_r, compare_mode_select_r};
  wire [DATA_W-1:0] rd_ctrl2 = {25'h0000000, trigger_status_flag_r, 6'h00};
  wire [DATA_W-1:0] rd_data = hit_ctrl1 ? rd_ctrl1 :
                              hit_ctrl2 ? rd_ctrl2 :
                              hit_pri ? {16'h0000, pri_shadow_r} :
                              hit_sec ? {16'h0000, sec_shadow_r} :
                              hit_tmr ? {16'h0000, timer_val} :
                              hit_period ? {16'h0000, period_r} :
                              hit_stat ? {29'h00000000, irq_stat_r} :
                              hit_mask ? {29'h00000000, irq_mask_r} : RDATA_ZERO;

  // Trigger flag: set wins over either clear
  wire trig_hw_clr = trigger_clear_policy_r && sec_match;
  wire trig_nxt = trigger_event || (trigger_status_flag_r && !(sw_trig_clr || trig_hw_clr));

  wire [IRQ_W-1:0] irq_events = {trigger_event, sec_match, pri_match};
  wire [IRQ_W-1:0] stat_nxt = irq_events | (irq_stat_r & ~stat_w1c);

  // One wait state: data is latched in the first access cycle
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pready_r <= 1'b0;
      prdata_r <= RDATA_ZERO;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= setup_rd;
      prdata_r <= setup_rd && !pwrite ? rd_data : RDATA_ZERO;
      pslverr_r <= setup_rd && !addr_hit;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      compare_mode_select_r <= MODE_OFF;
      trigger_clear_policy_r <= 1'b0;
      clk_sel_r <= 1'b0;
    end
    else if (mode_wr)
    begin
      compare_mode_select_r <= mode_new;
      trigger_clear_policy_r <= pwdata[CTRL1_POLICY_BIT];
      clk_sel_r <= pwdata[CTRL1_CLKSEL_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pri_shadow_r <= VAL_RST;
      sec_shadow_r <= VAL_RST;
      period_r <= PERIOD_RST;
      irq_mask_r <= IRQ_RST;
    end
    else
    begin
      if (wr && hit_pri)
        pri_shadow_r <= pwdata[VAL_W-1:0];
      if (wr && hit_sec)
        sec_shadow_r <= pwdata[VAL_W-1:0];
      if (wr && hit_period)
        period_r <= pwdata[VAL_W-1:0];
      if (wr && hit_mask)
        irq_mask_r <= pwdata[IRQ_W-1:0];
    end
  end

  // PWM copies reload only at period rollover or on a CTRL1 write, so a cycle is never torn
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pri_active_r <= VAL_RST;
      sec_active_r <= VAL_RST;
    end
    else if (!pwm_mode || timer_wrap || mode_wr)
    begin
      pri_active_r <= pri_shadow_r;
      sec_active_r <= sec_shadow_r;
    end
  end

  always_comb
  begin
    out_nxt = out_r;
    st_nxt = st_r;
    case (compare_mode_select_r)
      MODE_OFF:
      begin
        out_nxt = 1'b0;
        st_nxt = ST_IDLE;
      end
      MODE_SS_HIGH:
      begin
        if (st_r == ST_WAIT_PRI && pri_match)
        begin
          out_nxt = 1'b1;
          st_nxt = ST_DONE;
        end
      end
      MODE_SS_LOW:
      begin
        if (st_r == ST_WAIT_PRI && pri_match)
        begin
          out_nxt = 1'b0;
          st_nxt = ST_DONE;
        end
      end
      MODE_TOGGLE:
      begin
        if (pri_match)
          out_nxt = !out_r;
      end
      MODE_DBL_SINGLE, MODE_DBL_CONT:
      begin
        if (st_r == ST_WAIT_PRI && pri_match)
        begin
          out_nxt = !out_r;
          st_nxt = ST_WAIT_SEC;
        end
        else if (st_r == ST_WAIT_SEC && sec_match)
        begin
          out_nxt = !out_r;
          st_nxt = (compare_mode_select_r == MODE_DBL_CONT) ? ST_WAIT_PRI : ST_DONE;
        end
      end
      MODE_EPWM:
      begin
        // Low wins so a zero duty value keeps the pin low
        if (pri_match)
          out_nxt = 1'b0;
        else if (zero_match)
          out_nxt = 1'b1;
      end
      MODE_CPWM:
      begin
        if (sec_match)
          out_nxt = 1'b0;
        else if (pri_match)
          out_nxt = 1'b1;
      end
      default:
      begin
        out_nxt = out_r;
        st_nxt = st_r;
      end
    endcase
    if (mode_wr)
    begin
      out_nxt = (mode_new == MODE_SS_LOW);
      st_nxt = (mode_new == MODE_OFF) ? ST_IDLE : ST_WAIT_PRI;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      out_r <= 1'b0;
      st_r <= ST_IDLE;
      step_r <= 1'b0;
    end
    else
    begin
      out_r <= out_nxt;
      st_r <= st_nxt;
      step_r <= tick && !tmr_load;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      trigger_status_flag_r <= 1'b0;
      irq_stat_r <= IRQ_RST;
      irq_r <= 1'b0;
    end
    else
    begin
      trigger_status_flag_r <= trig_nxt;
      irq_stat_r <= stat_nxt;
      irq_r <= |(stat_nxt & irq_mask_r);
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign compare_output_pin = out_r;
  assign irq = irq_r;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  AST_TRIG_AUTO_CLR: assert property (trigger_clear_policy_r && sec_match && !trigger_event |=> !trigger_status_flag_r)
    else $error("trigger flag not cleared by secondary match");
  AST_TRIG_SW_ONLY: assert property (!trigger_clear_policy_r && trigger_status_flag_r && !sw_trig_clr
                                     |=> trigger_status_flag_r)
    else $error("trigger flag cleared without software");
  AST_CPWM: assert property (compare_mode_select_r == MODE_CPWM && !mode_wr && pri_match && !sec_match
                             |=> compare_output_pin ##1 (compare_output_pin || $past(sec_match)))
    else $error("center PWM did not rise on primary match");
  AST_EPWM: assert property (compare_mode_select_r == MODE_EPWM && !mode_wr && pri_match |=> !compare_output_pin)
    else $error("edge PWM did not fall on primary match");
  AST_DBL_CONT: assert property (compare_mode_select_r == MODE_DBL_CONT && !mode_wr && st_r == ST_WAIT_SEC && sec_match
                                 |=> st_r == ST_WAIT_PRI && compare_output_pin != $past(compare_output_pin))
    else $error("continuous pulse did not rearm");
  AST_DBL_ONE: assert property (compare_mode_select_r == MODE_DBL_SINGLE && !mode_wr && st_r == ST_DONE
                                |=> !compare_output_pin && st_r == ST_DONE)
    else $error("single pulse repeated");
  AST_TOGGLE: assert property (compare_mode_select_r == MODE_TOGGLE && !mode_wr && pri_match
                               |=> compare_output_pin != $past(compare_output_pin))
    else $error("toggle mode missed a match");
  AST_SS_LOW: assert property (compare_mode_select_r == MODE_SS_LOW && !mode_wr && st_r == ST_DONE |=> !compare_output_pin)
    else $error("single shot low not held");
  AST_SS_HIGH: assert property (compare_mode_select_r == MODE_SS_HIGH && !mode_wr && st_r == ST_WAIT_PRI && pri_match
                                |=> compare_output_pin [*2] or (compare_output_pin ##1 $past(mode_wr)))
    else $error("single shot high not forced");
  AST_OFF: assert property (compare_mode_select_r == MODE_OFF && !mode_wr && !tmr_load
                            |=> !compare_output_pin && $stable(timer_val))
    else $error("disabled channel shows activity");
  AST_BUFFER: assert property (pwm_mode && !timer_wrap && !mode_wr |=> $stable(pri_active_r) && $stable(sec_active_r))
    else $error("PWM compare value changed mid period");
  AST_PTG_CLK: assert property (compare_mode_select_r != MODE_OFF && clk_sel_r && !ptg_clk && !tmr_load
                                |=> $stable(timer_val))
    else $error("timer advanced without its trigger clock");
  AST_INIT: assert property (mode_wr && mode_new == MODE_SS_LOW |=> compare_output_pin && st_r == ST_WAIT_PRI)
    else $error("initial level not applied");
  AST_TRIG_SET: assert property (trigger_event |=> trigger_status_flag_r && irq_stat_r[IRQ_TRIG_BIT])
    else $error("trigger event lost");

  COV_CPWM_PULSE: cover property (compare_mode_select_r == MODE_CPWM && $rose(compare_output_pin) ##[1:50] $fell(compare_output_pin));
  COV_DBL_CONT: cover property (compare_mode_select_r == MODE_DBL_CONT && st_r == ST_WAIT_SEC ##[1:50] st_r == ST_WAIT_PRI);
  COV_AUTO_CLR: cover property (trigger_status_flag_r && trig_hw_clr);
  COV_IRQ: cover property ($rose(irq));

endmodule

// File: verification/pin_load.sv
// Load model on the compare output: counts rising edges and times high pulses
`timescale 1ns/1ps
module pin_load
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Observed pin and measurement restart
  input wire logic compare_output_pin,
  input wire logic clr,
  // Measurements
  output logic [7:0] rises,
  output logic [15:0] hi_width
);
  logic prev_r;
  logic [15:0] hi_cnt_r;

  // Width is only taken on a falling edge, so a pulse cut by clr reports only the part after clr
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      prev_r <= 1'b0;
      hi_cnt_r <= 16'h0000;
      rises <= 8'h00;
      hi_width <= 16'h0000;
    end
    else if (clr)
    begin
      prev_r <= compare_output_pin;
      hi_cnt_r <= 16'h0000;
      rises <= 8'h00;
      hi_width <= 16'h0000;
    end
    else
    begin
      prev_r <= compare_output_pin;
      if (compare_output_pin && !prev_r)
        rises <= rises + 8'h01;
      if (compare_output_pin)
        hi_cnt_r <= hi_cnt_r + 16'h0001;
      else
        hi_cnt_r <= 16'h0000;
      if (!compare_output_pin && prev_r)
        hi_width <= hi_cnt_r;
    end
  end
endmodule

// File: verification/testbench.sv
// Self-checking bench for the output compare channel
`timescale 1ns/1ps
module testbench;
  import ocmp_pkg::*;
  typedef struct packed {logic [2:0] mode; logic lvl0; logic lvl1; logic [7:0] rises; logic [15:0] width;} row_t;
  logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, trigger_event, compare_output_pin, irq, clr, e;
  logic [7:0] paddr, peripheral_trigger_generator, rises;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] hi_width;
  int mismatches, checks_done;
  row_t r;
  row_t rows [8];

  output_compare_channel dut (.core_clk(core_clk), .sys_rst(sys_rst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .peripheral_trigger_generator(peripheral_trigger_generator), .trigger_event(trigger_event),
    .compare_output_pin(compare_output_pin), .irq(irq));
  pin_load load (.core_clk(core_clk), .sys_rst(sys_rst), .compare_output_pin(compare_output_pin), .clr(clr),
    .rises(rises), .hi_width(hi_width));

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t ns: %s got %0h expected %0h", $time, msg, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq,
    output logic re);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      mismatches++;
      $display("wrong value at %0t ns: no ready", $time);
    end
    rq = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic trig();
    @(posedge core_clk);
    trigger_event <= 1'b1;
    @(posedge core_clk);
    trigger_event <= 1'b0;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    cyc(30000);
    mismatches++;
    test_done();
  end

  initial
  begin
    // Rises FF and width FFFF mean the figure depends on start-up phase and is skipped
    rows = '{{3'h0, 1'b0, 1'b0, 8'h00, 16'hFFFF}, {3'h1, 1'b0, 1'b1, 8'h01, 16'h0000},
      {3'h2, 1'b1, 1'b0, 8'h00, 16'hFFFF}, {3'h3, 1'b0, 1'b0, 8'h02, 16'h0040},
      {3'h4, 1'b0, 1'b0, 8'h01, 16'h001E}, {3'h5, 1'b0, 1'b1, 8'h04, 16'h001E},
      {3'h6, 1'b0, 1'b0, 8'h03, 16'h000A}, {3'h7, 1'b0, 1'b1, 8'h04, 16'h001E}};
    sys_rst = 1'b1;
    {psel, penable, pwrite, trigger_event, clr} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    peripheral_trigger_generator = 8'h00;
    cyc(3);
    chk({31'h0, compare_output_pin}, 32'h0, "pin in reset");
    chk({30'h0, irq, pready}, 32'h0, "irq ready in reset");
    @(posedge core_clk);
    sys_rst <= 1'b0;
    apb(1'b0, ADDR_CTRL1, 32'h0, q, e);
    chk(q, 32'h0, "ctrl1 reset");
    apb(1'b0, ADDR_PERIOD, 32'h0, q, e);
    chk(q, 32'h0000FFFF, "period reset");
    apb(1'b0, ADDR_IRQ_MASK, 32'h0, q, e);
    chk(q, 32'h0, "mask reset");
    apb(1'b0, 8'h20, 32'h0, q, e);
    chk({q[30:0], e}, 32'h1, "unmapped read");
    // Period 63 gives 64-cycle frames; primary 10 and secondary 40 set the pulse widths except in toggle mode
    wr(ADDR_PERIOD, 32'h3F);
    for (int i = 0; i < 8; i++)
    begin
      r = rows[i];
      wr(ADDR_CTRL1, 32'h0);
      wr(ADDR_TMR, 32'h0);
      wr(ADDR_PRI, 32'hA);
      wr(ADDR_SEC, 32'h28);
      wr(ADDR_CTRL1, {29'h0, r.mode});
      cyc(2);
      chk({31'h0, compare_output_pin}, {31'h0, r.lvl0}, "pin start");
      clr <= 1'b1;
      @(posedge core_clk);
      clr <= 1'b0;
      cyc(217);
      chk({31'h0, compare_output_pin}, {31'h0, r.lvl1}, "pin end");
      if (r.rises !== 8'hFF)
        chk({24'h0, rises}, {24'h0, r.rises}, "rise count");
      if (r.width !== 16'hFFFF)
        chk({16'h0, hi_width}, {16'h0, r.width}, "pulse width");
    end
    // A late primary change must act at once outside PWM and wait for the next frame in PWM
    for (int i = 0; i < 2; i++)
    begin
      wr(ADDR_CTRL1, 32'h0);
      wr(ADDR_TMR, 32'h0);
      wr(ADDR_PRI, 32'h1E);
      wr(ADDR_CTRL1, (i == 0) ? 32'h1 : 32'h6);
      cyc((i == 0) ? 2 : 66);
      wr(ADDR_PRI, 32'h2);
      cyc((i == 0) ? 34 : 40);
      chk({31'h0, compare_output_pin}, 32'h0, "late primary");
    end
    wr(ADDR_CTRL1, 32'h5);
    wr(ADDR_IRQ_STAT, 32'h7);
    wr(ADDR_IRQ_MASK, 32'h4);
    trig();
    cyc(3);
    chk({31'h0, irq}, 32'h1, "irq on trigger");
    cyc(100);
    apb(1'b0, ADDR_CTRL2, 32'h0, q, e);
    chk({31'h0, q[6]}, 32'h1, "flag kept");
    wr(ADDR_CTRL2, 32'h40);
    apb(1'b0, ADDR_CTRL2, 32'h0, q, e);
    chk({31'h0, q[6]}, 32'h0, "flag sw clear");
    wr(ADDR_IRQ_STAT, 32'h4);
    cyc(2);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    wr(ADDR_IRQ_MASK, 32'h0);
    trig();
    cyc(3);
    chk({31'h0, irq}, 32'h0, "irq masked");
    wr(ADDR_IRQ_MASK, 32'h4);
    cyc(3);
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    wr(ADDR_IRQ_STAT, 32'h7);
    wr(ADDR_CTRL2, 32'h40);
    wr(ADDR_CTRL1, 32'hD);
    trig();
    cyc(100);
    apb(1'b0, ADDR_IRQ_STAT, 32'h0, q, e);
    chk({31'h0, q[2]}, 32'h1, "trigger seen");
    apb(1'b0, ADDR_CTRL2, 32'h0, q, e);
    chk({31'h0, q[6]}, 32'h0, "flag auto clear");
    // Timer on generator output 4 only: other outputs high must not move it
    wr(ADDR_CTRL1, 32'h0);
    wr(ADDR_TMR, 32'h0);
    wr(ADDR_PRI, 32'hA);
    peripheral_trigger_generator <= 8'hEF;
    wr(ADDR_CTRL1, 32'h11);
    cyc(40);
    apb(1'b0, ADDR_TMR, 32'h0, q, e);
    chk(q, 32'h0, "timer held");
    peripheral_trigger_generator <= 8'h10;
    cyc(40);
    chk({31'h0, compare_output_pin}, 32'h1, "gen clocked");
    // Reset in mid-run must drop the pin at once and clear the control word
    sys_rst <= 1'b1;
    cyc(2);
    chk({31'h0, compare_output_pin}, 32'h0, "pin after mid reset");
    @(posedge core_clk);
    sys_rst <= 1'b0;
    apb(1'b0, ADDR_CTRL1, 32'h0, q, e);
    chk(q, 32'h0, "ctrl1 after mid reset");
    test_done();
  end
endmodule
